// File: async_serial_uart_mode_tb.sv
`timescale 1ns/1ps
`include "uart_async_defines.vh"
module async_serial_uart_mode_tb;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [2:0]  regAddr = 3'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        handshakePinIn = 1'b0;
   logic        transferClockPin = 1'b0;
   wire  [15:0] regRdData;
   wire         irq, rxLine, serialOutPin, serialOutPinEn, handshakePinOut, handshakePinEn;
   wire         txLine = serialOutPinEn ? serialOutPin : 1'b1;
   int          failures = 0;
   int          checked = 0;
   logic [15:0] rd;
   logic [11:0] frame;
   bit          ok;

   always #2 clk = ~clk;

   uart_async_channel #(.IS_CH2(1)) uut (
      .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .irq(irq), .serialInPin(rxLine),
      .serialOutPin(serialOutPin), .serialOutPinEn(serialOutPinEn),
      .transferClockPin(transferClockPin), .handshakePinIn(handshakePinIn),
      .handshakePinOut(handshakePinOut), .handshakePinEn(handshakePinEn));
   remote_serial #(.BIT(32)) peer (.clk(clk), .lineIn(txLine), .lineOut(rxLine));

   // ***********************************
   // Bus cycles and comparison
   // ***********************************
   task automatic conclude;
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic expect16(input logic [15:0] got, input logic [15:0] want);
      checked++;
      if (got !== want)
      begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdReg(input logic [2:0] a, input logic [15:0] mask, input logic [15:0] want);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
      rd = regRdData;
      expect16(rd & mask, want);
   endtask
   function automatic logic [11:0] mk(input logic [7:0] d);
      mk = {1'b1, 1'b1, ^d, d, 1'b0};
   endfunction
   task automatic txFrame(input logic [7:0] d, input logic idle);
      fork
         peer.capture(12, idle, frame, ok);
         wr(`UA_REG_TXBUF, {8'h00, d});
      join
      if (!ok)
      begin
         failures++;
         conclude();
      end
   endtask
   task automatic rxFrame(input logic [11:0] f);
      peer.send(f, 12);
      repeat (4) @(posedge clk);
   endtask

   // ***********************************
   // Scenarios
   // ***********************************
   task automatic resetValues;
      rdReg(`UA_REG_CTL0, 16'hFFFF, {8'h00, `UA_CTL0_RST});
      rdReg(`UA_REG_BRG, 16'hFFFF, {8'h00, `UA_BRG_RST});
      expect16({14'h0, serialOutPin, serialOutPinEn}, 16'h0003);
      wr(`UA_REG_MODE, 16'h0088);
      rdReg(`UA_REG_MODE, 16'h0088, 16'h0000);
   endtask
   task automatic txNormal;
      wr(`UA_REG_MODE, 16'h0041);
      wr(`UA_REG_BRG, 16'h0001);
      wr(`UA_REG_CTL1, 16'h0005);
      txFrame(8'hA5, 1'b1);
      expect16({4'h0, frame}, {4'h0, mk(8'hA5)});
      rdReg(`UA_REG_ISTAT, 16'h0003, 16'h0003);
      expect16({15'h0, irq}, 16'h0000);
      wr(`UA_REG_IMASK, 16'h0002);
      expect16({15'h0, irq}, 16'h0001);
      wr(`UA_REG_ISTAT, 16'h001F);
      expect16({15'h0, irq}, 16'h0000);
   endtask
   task automatic dataInvert;
      wr(`UA_REG_CTL1, 16'h0045);
      txFrame(8'h3C, 1'b1);
      expect16({4'h0, frame}, {4'h0, mk(8'hC3)});
      rxFrame(mk(8'h96));
      rdReg(`UA_REG_RXBUF, 16'h00FF, 16'h0069);
      wr(`UA_REG_CTL1, 16'h0005);
   endtask
   task automatic polarity;
      fork
         peer.send(12'h000, 1);
         wr(`UA_REG_CTL0, 16'h0040);
      join
      expect16({15'h0, serialOutPin}, 16'h0000);
      txFrame(8'h81, 1'b0);
      expect16({4'h0, frame}, {4'h0, ~mk(8'h81)});
      rxFrame(~mk(8'h5A));
      rdReg(`UA_REG_RXBUF, 16'h00FF, 16'h005A);
      fork
         peer.send(12'h001, 1);
         wr(`UA_REG_CTL0, 16'h0000);
      join
      wr(`UA_REG_ISTAT, 16'h001F);
   endtask
   task automatic rxErrors;
      rxFrame(mk(8'h11));
      rdReg(`UA_REG_ISTAT, 16'h0004, 16'h0004);
      wr(`UA_REG_ISTAT, 16'h0004);
      rxFrame(mk(8'h22));
      rdReg(`UA_REG_ISTAT, 16'h0004, 16'h0000);
      rdReg(`UA_REG_RXBUF, 16'hF0FF, 16'h9022);
      wr(`UA_REG_CTL1, 16'h0001);
      wr(`UA_REG_CTL1, 16'h0005);
      rxFrame(mk(8'h33) ^ 12'h200);
      rdReg(`UA_REG_RXBUF, 16'hF0FF, 16'hC033);
      wr(`UA_REG_CTL1, 16'h0001);
      wr(`UA_REG_CTL1, 16'h0005);
      rxFrame(mk(8'h44) & 12'hBFF);
      rdReg(`UA_REG_RXBUF, 16'hF0FF, 16'hA044);
      wr(`UA_REG_ISTAT, 16'h001F);
   endtask
   task automatic collision;
      int w;
      w = 0;
      wr(`UA_REG_IMASK, 16'h0010);
      fork
         peer.send(mk(8'h00), 12);
         wr(`UA_REG_TXBUF, 16'h00FF);
      join
      while (irq !== 1'b1 && w < 2000)
      begin
         @(posedge clk);
         w++;
      end
      if (w >= 2000)
      begin
         failures++;
         conclude();
      end
      rdReg(`UA_REG_ISTAT, 16'h0010, 16'h0010);
      wr(`UA_REG_ISTAT, 16'h001F);
      expect16({15'h0, irq}, 16'h0000);
   endtask
   task automatic handshake;
      wr(`UA_REG_CTL0, 16'h0004);
      expect16({14'h0, handshakePinEn, handshakePinOut}, 16'h0003);
      rdReg(`UA_REG_RXBUF, 16'hF1FF, 16'h0000);
      expect16({14'h0, handshakePinEn, handshakePinOut}, 16'h0002);
      wr(`UA_REG_CTL0, 16'h0014);
      expect16({15'h0, handshakePinEn}, 16'h0000);
      wr(`UA_REG_CTL0, 16'h0024);
      expect16({15'h0, serialOutPinEn}, 16'h0000);
      wr(`UA_REG_CTL0, 16'h0000);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      failures++;
      conclude();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      resetValues();
      txNormal();
      dataInvert();
      polarity();
      rxErrors();
      collision();
      handshake();
      conclude();
   end
endmodule // async_serial_uart_mode_tb

// File: bit_rate_divider.v
`timescale 1ns/1ps
module bit_rate_divider #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             srst,
   input  wire             srcTick,
   input  wire [WIDTH-1:0] divisor,
   output wire             tick
);
   reg [WIDTH-1:0] count_ff;
   reg             tick_ff;

   // Divide source ticks by n+1
   always @(posedge clk)
   begin
      if (srst)
      begin
         count_ff <= {WIDTH{1'b0}};
         tick_ff  <= 1'b0;
      end
      else
      begin
         tick_ff <= 1'b0;
         if (srcTick)
         begin
            if (count_ff >= divisor)
            begin
               count_ff <= {WIDTH{1'b0}};
               tick_ff  <= 1'b1;
            end
            else
               count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   assign tick = tick_ff;
endmodule // bit_rate_divider

// File: remote_serial.sv
`timescale 1ns/1ps
module remote_serial #(
   parameter BIT = 32
) (
   input  wire logic clk,
   input  wire logic lineIn,
   output logic      lineOut
);
   initial lineOut = 1'b1;

   // Bits leave LSB first; the line keeps the last level afterwards
   task automatic send(input logic [11:0] frame, input int n);
      for (int i = 0; i < n; i++)
      begin
         lineOut <= frame[i];
         repeat (BIT) @(posedge clk);
      end
   endtask

   // Mid-bit sampling after the first departure from idle
   task automatic capture(input int n, input logic idle, output logic [11:0] frame,
                          output bit ok);
      int w;
      frame = 12'h000;
      w = 0;
      while (lineIn === idle && w < 20000)
      begin
         @(posedge clk);
         w++;
      end
      ok = (w < 20000);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         frame[i] = lineIn;
         repeat (BIT) @(posedge clk);
      end
   endtask
endmodule // remote_serial

// File: uart_async_channel.v
`timescale 1ns/1ps
`include "uart_async_defines.vh"
module uart_async_channel #(
   parameter IS_CH2 = 0
) (
   input  wire        clk,
   input  wire        srst,
   input  wire [2:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [15:0] regRdData,
   output wire        irq,
   input  wire        serialInPin,
   output wire        serialOutPin,
   output wire        serialOutPinEn,
   input  wire        transferClockPin,
   input  wire        handshakePinIn,
   output wire        handshakePinOut,
   output wire        handshakePinEn
);
   localparam S_IDLE   = 3'h0;
   localparam S_START  = 3'h1;
   localparam S_DATA   = 3'h2;
   localparam S_PARITY = 3'h3;
   localparam S_STOP   = 3'h4;

   // ***********************************
   // Registers and pin synchronisers
   // ***********************************
   reg [7:0]  mode_ff, ctl0_ff, brg_ff;
   reg [2:0]  ctl1_ff;
   reg [8:0]  txBuf_ff, rxBuf_ff;
   reg        txFull_ff, rxFull_ff;
   reg        ovrErr_ff, frmErr_ff, parErr_ff;
   reg [`UA_IRQ_BITS-1:0] stat_ff, mask_ff;
   reg [1:0]  rxSync_ff, clkSync_ff, ctsSync_ff;
   reg        clkPrev_ff;
   reg [4:0]  pre_ff;

   // Channel 2 has no sleep and no external clock; 0/1 have no inversion
   wire sleepOn  = (IS_CH2 == 0) & mode_ff[`UA_MODE_SLEEP];
   wire extClkOn = (IS_CH2 == 0) & mode_ff[`UA_MODE_EXTCLK];
   wire invOn    = (IS_CH2 != 0) & ctl1_ff[2];
   wire polRev   = (IS_CH2 != 0) & ctl0_ff[`UA_CTL0_POLREV];
   wire [1:0] charLen = mode_ff[1:0];
   wire [8:0] charMask = (charLen == `UA_LEN7) ? 9'h07F :
                         (charLen == `UA_LEN8) ? 9'h0FF : 9'h1FF;
   wire [3:0] lastIdx = (charLen == `UA_LEN7) ? 4'h6 :
                        (charLen == `UA_LEN8) ? 4'h7 : 4'h8;

   always @(posedge clk)
   begin
      if (srst)
      begin
         rxSync_ff  <= 2'h3;
         clkSync_ff <= 2'h0;
         ctsSync_ff <= 2'h3;
         clkPrev_ff <= 1'b0;
         pre_ff     <= 5'h00;
      end
      else
      begin
         rxSync_ff  <= {rxSync_ff[0], serialInPin};
         clkSync_ff <= {clkSync_ff[0], transferClockPin};
         ctsSync_ff <= {ctsSync_ff[0], handshakePinIn};
         clkPrev_ff <= clkSync_ff[1];
         pre_ff     <= pre_ff + 5'h01;
      end
   end

   // ***********************************
   // Bit clock source
   // ***********************************
   wire extEdge = clkSync_ff[1] & ~clkPrev_ff;
   reg  intTick;
   always @*
   begin
      case (ctl0_ff[1:0])
         `UA_SRC_F1:  intTick = 1'b1;
         `UA_SRC_F8:  intTick = ({2'h0, pre_ff[2:0]} == `UA_PRE_F8_END);
         `UA_SRC_F32: intTick = (pre_ff == `UA_PRE_F32_END);
         default:     intTick = 1'b1;
      endcase
   end
   wire tick16;
   bit_rate_divider #(.WIDTH(8)) rateDiv (
      .clk     (clk),
      .srst    (srst),
      .srcTick (extClkOn ? extEdge : intTick),
      .divisor (brg_ff),
      .tick    (tick16)
   );

   wire rxLine = rxSync_ff[1] ^ polRev;
   wire rtsMode = ~ctl0_ff[`UA_CTL0_HSDIS] & ctl0_ff[`UA_CTL0_RTSSEL];
   wire ctsMode = ~ctl0_ff[`UA_CTL0_HSDIS] & ~ctl0_ff[`UA_CTL0_RTSSEL];

   // ***********************************
   // Transmitter
   // ***********************************
   reg [2:0] txState_ff;
   reg [3:0] txSub_ff, txIdx_ff;
   reg [8:0] txShift_ff;
   reg       txPar_ff, txStop2_ff, txLine_ff;
   reg       evTxLoad, evTxDone, evBusCol;
   wire      txStart = txState_ff == S_IDLE && tick16 && ctl1_ff[0] && txFull_ff
                       && (!ctsMode || !ctsSync_ff[1]);
   wire      txBitEnd = tick16 && txSub_ff == `UA_OVS_LAST;
   wire      outLevel = txLine_ff ^ polRev;

   always @(posedge clk)
   begin
      if (srst)
      begin
         txState_ff <= S_IDLE;
         txSub_ff   <= 4'h0;
         txIdx_ff   <= 4'h0;
         txShift_ff <= 9'h000;
         txPar_ff   <= 1'b0;
         txStop2_ff <= 1'b0;
         txLine_ff  <= 1'b1;
         evTxLoad   <= 1'b0;
         evTxDone   <= 1'b0;
      end
      else
      begin
         evTxLoad <= 1'b0;
         evTxDone <= 1'b0;
         if (tick16 && txState_ff != S_IDLE)
            txSub_ff <= txSub_ff + 4'h1;
         case (txState_ff)
            S_IDLE:
               if (txStart)
               begin
                  txShift_ff <= txBuf_ff & charMask;
                  txPar_ff   <= (^(txBuf_ff & charMask)) ^ mode_ff[`UA_MODE_ODD];
                  txStop2_ff <= mode_ff[`UA_MODE_STOP2];
                  txSub_ff   <= 4'h0;
                  txLine_ff  <= 1'b0;
                  evTxLoad   <= 1'b1;
                  txState_ff <= S_START;
               end
            S_START:
               if (txBitEnd)
               begin
                  txIdx_ff   <= 4'h0;
                  txLine_ff  <= txShift_ff[0];
                  txState_ff <= S_DATA;
               end
            S_DATA:
               if (txBitEnd)
               begin
                  if (txIdx_ff == lastIdx)
                  begin
                     txLine_ff  <= mode_ff[`UA_MODE_PAREN] ? txPar_ff : 1'b1;
                     txState_ff <= mode_ff[`UA_MODE_PAREN] ? S_PARITY : S_STOP;
                  end
                  else
                  begin
                     txShift_ff <= {1'b0, txShift_ff[8:1]};
                     txLine_ff  <= txShift_ff[1];
                     txIdx_ff   <= txIdx_ff + 4'h1;
                  end
               end
            S_PARITY:
               if (txBitEnd)
               begin
                  txLine_ff  <= 1'b1;
                  txState_ff <= S_STOP;
               end
            S_STOP:
               if (txBitEnd)
               begin
                  if (txStop2_ff)
                     txStop2_ff <= 1'b0;
                  else
                  begin
                     evTxDone   <= 1'b1;
                     txState_ff <= S_IDLE;
                  end
               end
            default: txState_ff <= S_IDLE;
         endcase
      end
   end

   // Compare at the rising bit-clock point, mid-cell, so the pin has settled
   always @*
      evBusCol = (IS_CH2 != 0) && txState_ff != S_IDLE && tick16
                 && txSub_ff == `UA_OVS_COMPARE
                 && outLevel != rxSync_ff[1];

   // ***********************************
   // Receiver
   // ***********************************
   reg [2:0] rxState_ff;
   reg [3:0] rxSub_ff, rxIdx_ff;
   reg [8:0] rxShift_ff;
   reg       rxParBad_ff, rxFrmBad_ff, rxStop2_ff;
   reg       rxStore;
   wire      rxMid = tick16 && rxSub_ff == `UA_OVS_LAST;
   wire      rdRx  = regRd && regAddr == `UA_REG_RXBUF;
   wire      rxKeep = !sleepOn || rxShift_ff[lastIdx];

   always @(posedge clk)
   begin
      if (srst)
      begin
         rxState_ff  <= S_IDLE;
         rxSub_ff    <= 4'h0;
         rxIdx_ff    <= 4'h0;
         rxShift_ff  <= 9'h000;
         rxParBad_ff <= 1'b0;
         rxFrmBad_ff <= 1'b0;
         rxStop2_ff  <= 1'b0;
         rxStore     <= 1'b0;
      end
      else
      begin
         rxStore <= 1'b0;
         if (tick16)
            rxSub_ff <= rxSub_ff + 4'h1;
         case (rxState_ff)
            S_IDLE:
               if (tick16 && ctl1_ff[1] && !rxLine)
               begin
                  rxSub_ff   <= 4'h0;
                  rxState_ff <= S_START;
               end
            S_START:
               if (tick16 && rxSub_ff == `UA_OVS_MID)
               begin
                  // Glitch shorter than half a bit is dropped
                  rxSub_ff    <= 4'h0;
                  rxIdx_ff    <= 4'h0;
                  rxShift_ff  <= 9'h000;
                  rxParBad_ff <= 1'b0;
                  rxFrmBad_ff <= 1'b0;
                  rxStop2_ff  <= mode_ff[`UA_MODE_STOP2];
                  rxState_ff  <= rxLine ? S_IDLE : S_DATA;
               end
            S_DATA:
               if (rxMid)
               begin
                  rxShift_ff[rxIdx_ff] <= rxLine;
                  rxIdx_ff <= rxIdx_ff + 4'h1;
                  if (rxIdx_ff == lastIdx)
                     rxState_ff <= mode_ff[`UA_MODE_PAREN] ? S_PARITY : S_STOP;
               end
            S_PARITY:
               if (rxMid)
               begin
                  rxParBad_ff <= (^rxShift_ff) ^ mode_ff[`UA_MODE_ODD] ^ rxLine;
                  rxState_ff  <= S_STOP;
               end
            S_STOP:
               if (rxMid)
               begin
                  rxFrmBad_ff <= rxFrmBad_ff | !rxLine;
                  if (rxStop2_ff)
                     rxStop2_ff <= 1'b0;
                  else
                  begin
                     rxStore    <= 1'b1;
                     rxState_ff <= S_IDLE;
                  end
               end
            default: rxState_ff <= S_IDLE;
         endcase
      end
   end

   // ***********************************
   // Register file and receive buffer
   // ***********************************
   wire wrTx   = regWr && regAddr == `UA_REG_TXBUF;
   wire doStore = rxStore && rxKeep && ctl1_ff[1];
   wire overrun = rxFull_ff && !rdRx;
   wire [8:0] rxData = invOn ? (~rxBuf_ff & charMask) : rxBuf_ff;
   wire [`UA_IRQ_BITS-1:0] events = {evBusCol,
      doStore && (overrun || rxFrmBad_ff || rxParBad_ff),
      doStore && !overrun, evTxDone, evTxLoad};
   // Other-channel MODE and CTL0 bits and unused CTL0 bits never store, so they read back as zero
   wire [7:0] modeKeep = (IS_CH2 != 0) ? 8'h77 : 8'hFF;
   wire [7:0] ctl0Keep = (IS_CH2 != 0) ? 8'h77 : 8'h37;

   always @(posedge clk)
   begin
      if (srst)
      begin
         mode_ff   <= `UA_MODE_RST;
         ctl0_ff   <= `UA_CTL0_RST;
         ctl1_ff   <= 3'h0;
         brg_ff    <= `UA_BRG_RST;
         txBuf_ff  <= 9'h000;
         rxBuf_ff  <= 9'h000;
         txFull_ff <= 1'b0;
         rxFull_ff <= 1'b0;
         ovrErr_ff <= 1'b0;
         frmErr_ff <= 1'b0;
         parErr_ff <= 1'b0;
         stat_ff   <= {`UA_IRQ_BITS{1'b0}};
         mask_ff   <= {`UA_IRQ_BITS{1'b0}};
         regRdData <= 16'h0000;
      end
      else
      begin
         if (regWr)
         begin
            case (regAddr)
               `UA_REG_MODE:  mode_ff <= regWrData[7:0] & modeKeep;
               `UA_REG_CTL0:  ctl0_ff <= regWrData[7:0] & ctl0Keep;
               `UA_REG_CTL1:  ctl1_ff <= {regWrData[`UA_CTL1_INV],
                                 regWrData[`UA_CTL1_RXEN], regWrData[`UA_CTL1_TXEN]};
               `UA_REG_BRG:   brg_ff <= regWrData[7:0];
               `UA_REG_TXBUF: txBuf_ff <= invOn ? (~regWrData[8:0] & charMask)
                                                : regWrData[8:0];
               `UA_REG_IMASK: mask_ff <= regWrData[`UA_IRQ_BITS-1:0];
               default: ;
            endcase
         end
         // A coincident software write wins over the hardware load
         if (evTxLoad)
            txFull_ff <= wrTx;
         else if (wrTx)
            txFull_ff <= 1'b1;
         if (doStore)
         begin
            rxBuf_ff  <= rxShift_ff & charMask;
            rxFull_ff <= 1'b1;
            ovrErr_ff <= ovrErr_ff | overrun;
            frmErr_ff <= rxFrmBad_ff;
            parErr_ff <= rxParBad_ff;
         end
         else if (rdRx)
            rxFull_ff <= 1'b0;
         // Errors clear when the receiver is switched off; a coincident store wins
         if (regWr && regAddr == `UA_REG_CTL1 && !regWrData[`UA_CTL1_RXEN] && !doStore)
         begin
            ovrErr_ff <= 1'b0;
            frmErr_ff <= 1'b0;
            parErr_ff <= 1'b0;
         end
         // Write one to clear; a new event in the same cycle wins
         if (regWr && regAddr == `UA_REG_ISTAT)
            stat_ff <= (stat_ff & ~regWrData[`UA_IRQ_BITS-1:0]) | events;
         else
            stat_ff <= stat_ff | events;
         regRdData <= 16'h0000;
         if (regRd)
         begin
            case (regAddr)
               `UA_REG_MODE:  regRdData <= {8'h00, mode_ff};
               `UA_REG_CTL0:  regRdData <= {8'h00, ctl0_ff};
               `UA_REG_CTL1:  regRdData <= {9'h000, ctl1_ff[2], 2'h0, rxFull_ff,
                                 ctl1_ff[1], !txFull_ff, ctl1_ff[0]};
               `UA_REG_BRG:   regRdData <= {8'h00, brg_ff};
               `UA_REG_TXBUF: regRdData <= {7'h00, txBuf_ff};
               `UA_REG_RXBUF: regRdData <= {ovrErr_ff | frmErr_ff | parErr_ff,
                                 parErr_ff, frmErr_ff, ovrErr_ff, 3'h0, rxData};
               `UA_REG_ISTAT: regRdData <= {11'h000, stat_ff};
               `UA_REG_IMASK: regRdData <= {11'h000, mask_ff};
               default:       regRdData <= 16'h0000;
            endcase
         end
      end
   end

   // ***********************************
   // Pins and interrupt
   // ***********************************
   // Open drain only ever pulls low; a high level floats
   assign serialOutPin    = ctl0_ff[`UA_CTL0_OPENDR] ? 1'b0 : outLevel;
   assign serialOutPinEn  = ctl0_ff[`UA_CTL0_OPENDR] ? ~outLevel : 1'b1;
   // Request-to-send low while the receive buffer can take a character
   assign handshakePinOut = ~(ctl1_ff[1] & ~rxFull_ff);
   assign handshakePinEn  = rtsMode;
   assign irq = |(stat_ff & mask_ff);
endmodule // uart_async_channel

// File: uart_async_channel_sva.sv
`timescale 1ns/1ps
module uart_async_channel_sva #(
   parameter IS_CH2 = 0
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [2:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [15:0] regRdData,
   input wire logic        irq,
   input wire logic        serialInPin,
   input wire logic        serialOutPin,
   input wire logic        serialOutPinEn,
   input wire logic        transferClockPin,
   input wire logic        handshakePinIn,
   input wire logic        handshakePinOut,
   input wire logic        handshakePinEn
);
   // ***********************************
   // Shadow of control bits and line timing
   // ***********************************
   reg  [6:0] ctl0Sh_ff;
   reg        txEnSh_ff;
   reg        wr1_ff;
   reg        wr2_ff;
   reg        lastPin_ff;
   reg  [7:0] since_ff;
   wire       polBit = (IS_CH2 != 0) && ctl0Sh_ff[6];
   wire       quiet  = !wr1_ff && !wr2_ff;

   always @(posedge clk)
   begin
      wr1_ff     <= regWr && !srst;
      wr2_ff     <= wr1_ff;
      lastPin_ff <= serialOutPin;
      if (srst)
      begin
         ctl0Sh_ff <= 7'h00;
         txEnSh_ff <= 1'b0;
         since_ff  <= 8'hFF;
      end
      else
      begin
         if (regWr && regAddr == 3'h1)
            ctl0Sh_ff <= regWrData[6:0];
         if (regWr && regAddr == 3'h2)
            txEnSh_ff <= regWrData[0];
         // Edges caused by control writes do not restart the bit timer
         if (serialOutPin != lastPin_ff && quiet)
            since_ff <= 8'h00;
         else if (since_ff != 8'hFF)
            since_ff <= since_ff + 8'h01;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   // ***********************************
   // Properties
   // ***********************************
   sequence s_quiet;
      quiet;
   endsequence
   sequence s_lineMove;
      $changed(serialOutPin) ##0 s_quiet;
   endsequence

   property p_resetIdle;
      disable iff (1'b0) srst |=> serialOutPin && serialOutPinEn && !handshakePinEn;
   endproperty
   property p_hsRole;
      s_quiet |-> handshakePinEn == (!ctl0Sh_ff[4] && ctl0Sh_ff[2]);
   endproperty
   property p_openDrain;
      s_quiet ##0 ctl0Sh_ff[5] |-> !serialOutPin;
   endproperty
   property p_idleLevel;
      s_quiet ##0 (!txEnSh_ff && !ctl0Sh_ff[5]) |-> serialOutPin == !polBit;
   endproperty
   property p_startGate;
      s_quiet ##0 !ctl0Sh_ff[5] ##0 $fell(serialOutPin ^ polBit) |-> txEnSh_ff;
   endproperty
   property p_bitHold;
      s_lineMove |-> since_ff >= 8'd15;
   endproperty
   property p_irqHold;
      irq && !regWr |=> irq;
   endproperty
   property p_ch2Read;
      (IS_CH2 != 0) && regRd && regAddr == 3'h0 |=> !regRdData[7] && !regRdData[3];
   endproperty

   a_resetIdle: assert property (p_resetIdle)
      else $error("line not idle high after reset");
   a_hsRole: assert property (p_hsRole)
      else $error("handshake pin role wrong");
   a_openDrain: assert property (p_openDrain)
      else $error("open drain output drives high");
   a_idleLevel: assert property (p_idleLevel)
      else $error("idle level wrong");
   a_startGate: assert property (p_startGate)
      else $error("start bit without transmit enable");
   a_bitHold: assert property (p_bitHold)
      else $error("bit shorter than sixteen ticks");
   a_irqHold: assert property (p_irqHold)
      else $error("interrupt dropped without a write");
   a_ch2Read: assert property (p_ch2Read)
      else $error("sleep or clock select readable on channel 2");
endmodule // uart_async_channel_sva

bind uart_async_channel uart_async_channel_sva #(.IS_CH2(IS_CH2)) chk (
   .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
   .regRd(regRd), .regRdData(regRdData), .irq(irq), .serialInPin(serialInPin),
   .serialOutPin(serialOutPin), .serialOutPinEn(serialOutPinEn),
   .transferClockPin(transferClockPin), .handshakePinIn(handshakePinIn),
   .handshakePinOut(handshakePinOut), .handshakePinEn(handshakePinEn));

// File: uart_async_defines.vh
// Overview of operation
// - Bit-rate divisor n accepts any value 0x00 to 0xFF per channel.
// - External clock mode takes its source from the transfer clock pin.
// - Overrun overwrites receive buffer; receive interrupt request stays unchanged.
// - Sleep mode stores only characters whose MSB is one.
// - Sleep only on channels 0/1; inversion and polarity reverse only on channel 2.
// - Channel 2 data logic bit inverts data on buffer write and read.
// - Data inversion touches character bits only, never start, parity or stop.
// - Channel 2 polarity reverse inverts every line level; default is normal.
// - Channel 2 compares output and input pins once per bit, mid-cell, while sending; mismatch interrupts.
// - Serial output idles high (low with channel 2 polarity reverse); open-drain floats a high level.
// - Clock pin is clock input only when external clock selected; never channel 2.
// - Handshake pin is request-to-send output when enabled and selected, clear-to-send input when enabled but not selected, else general.
// - Internal bit rate is fi/16(n+1) with fi from f1, f8 or f32.
// - Frame: one start, 7/8/9 data, odd/even/no parity, one or two stops.
// - Transmit starts only with enable, data present and clear-to-send low if used.
// - Overrun, framing and parity errors flagged, with an error sum flag.
`ifndef UART_ASYNC_DEFINES_VH
`define UART_ASYNC_DEFINES_VH

// ***********************************
// Register offsets
// ***********************************
`define UA_REG_MODE     3'h0
`define UA_REG_CTL0     3'h1
`define UA_REG_CTL1     3'h2
`define UA_REG_BRG      3'h3
`define UA_REG_TXBUF    3'h4
`define UA_REG_RXBUF    3'h5
`define UA_REG_ISTAT    3'h6
`define UA_REG_IMASK    3'h7

// ***********************************
// Field positions
// ***********************************
`define UA_MODE_EXTCLK  3
`define UA_MODE_STOP2   4
`define UA_MODE_ODD     5
`define UA_MODE_PAREN   6
`define UA_MODE_SLEEP   7
`define UA_CTL0_RTSSEL  2
`define UA_CTL0_HSDIS   4
`define UA_CTL0_OPENDR  5
`define UA_CTL0_POLREV  6
`define UA_CTL1_TXEN    0
`define UA_CTL1_TXEMPTY 1
`define UA_CTL1_RXEN    2
`define UA_CTL1_RXFULL  3
`define UA_CTL1_INV     6
`define UA_RX_OVR       12
`define UA_RX_FRM       13
`define UA_RX_PAR       14
`define UA_RX_SUM       15

// Interrupt status bits
`define UA_IRQ_TXLOAD   0
`define UA_IRQ_TXDONE   1
`define UA_IRQ_RXFULL   2
`define UA_IRQ_ERR      3
`define UA_IRQ_BUSCOL   4
`define UA_IRQ_BITS     5

// ***********************************
// Reset values and encodings
// ***********************************
`define UA_MODE_RST     8'h00
`define UA_CTL0_RST     8'h00
`define UA_CTL1_RST     8'h00
`define UA_BRG_RST      8'h00
`define UA_LEN7         2'h0
`define UA_LEN8         2'h1
`define UA_LEN9         2'h2
`define UA_SRC_F1       2'h0
`define UA_SRC_F8       2'h1
`define UA_SRC_F32      2'h2
`define UA_PRE_F8_END   5'h07
`define UA_PRE_F32_END  5'h1F
`define UA_OVS_LAST     4'hF
`define UA_OVS_MID      4'h7
`define UA_OVS_COMPARE  4'h8

`endif
